// *** hw/fblp_map.svh ***
// Offsets, fields, reset values and limits of the flash lock block.
// Assumes a word-addressed 8K-word program flash behind the core.
//
// Contract
// - Boot-size fuses pick boot start and size.
// - Application below boot start; boot through top.
// - Concurrent-read region fixed below 0x1C00.
// - Page index from pointer bits 13..7.
// - Word index from pointer bits 6..1.
// - Pointer bits 15..14 ignored; bit 0 byte.
// - Six lock bits, programmed reads 0.
// - Only chip erase returns lock bits to 1.
// - No-boot variant: stores need self-program fuse.
// - Memory lock mode 1 imposes nothing.
// - Mode 2 blocks programming, freezes fuses.
// - Mode 3 also blocks verify, freezes boot locks.
// - Application mode 1: loads and stores free.
// - Application mode 2: stores blocked, loads allowed.
// - Application mode 3: stores, cross loads blocked.
// - Application mode 4: cross loads blocked only.
// - Application modes 3,4 may mask interrupts.
// - Boot mode 1: loads and stores free.
// - Boot modes 2,3: stores blocked.
// - Boot modes 3,4: cross loads blocked.
// - Boot modes 3,4 may mask interrupts.
// - Fuses latched at power-up and programming entry; the preserve fuse acts straight from the image, unlatched.
`ifndef FBLP_MAP_SVH
`define FBLP_MAP_SVH

`define FBLP_OFS_LOCK      12'h000
`define FBLP_OFS_FUSE      12'h004
`define FBLP_OFS_CTRL      12'h008
`define FBLP_OFS_STAT      12'h00C

`define FBLP_LOCK_RESET    8'hFF
`define FBLP_LOCK_USED     8'h3F
`define FBLP_FUSE_RESET    8'hF9
`define FBLP_FUSE_USED     8'h1E

`define FBLP_FUSE_BSZ_LO   1
`define FBLP_FUSE_BSZ_HI   2
`define FBLP_FUSE_EEPROM_PRESERVE_FUSE   3
`define FBLP_FUSE_SELFPRG  4

`define FBLP_CTRL_PROG     0
`define FBLP_CTRL_ERASE    1
`define FBLP_CTRL_NOBOOT   2

`define FBLP_BOOT_128      13'h1F80
`define FBLP_BOOT_256      13'h1F00
`define FBLP_BOOT_512      13'h1E00
`define FBLP_BOOT_1024     13'h1C00
`define FBLP_STALL_START   13'h1C00
`define FBLP_HARMLESS      8'hFF

`endif

// *** hw/fblp_pkg.sv ***
// Types of the flash lock block.
// Assumes fblp_map.svh supplies the numeric constants.
package fblp_pkg;

	typedef struct packed {
		logic [7:0]  lock;
		logic [7:0]  fuse;
		logic [7:0]  fuse_lat;
		logic        prog_mode;
		logic        no_boot;
		logic        cap_pend;
		logic [31:0] prdata;
	} fblp_state_t;

endpackage

// *** hw/fblp_top.sv ***
// Flash region decode, lock byte, fuse image and permission checks.
// Assumes an APB master and a core access port in the clk_sys domain.
`timescale 1ns/1ps
`include "fblp_map.svh"
`default_nettype none

module fblp_top (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Core flash access
	input  wire logic        acc_valid,
	input  wire logic        acc_store,
	input  wire logic [15:0] acc_zptr,
	input  wire logic [12:0] cpu_pc,
	input  wire logic        ivt_in_boot,
	input  wire logic [15:0] flash_rdata,
	output logic             acc_allow,
	output logic             flash_we,
	output logic      [12:0] flash_word_addr,
	output logic      [6:0]  page_index,
	output logic      [5:0]  word_in_page_index,
	output logic      [7:0]  load_byte,
	output logic             irq_suppress,
	// Region status
	output logic      [12:0] boot_start,
	output logic             target_in_boot,
	output logic             concurrent_read_region,
	output logic             stalled_read_region,
	// Programmer permissions
	output logic             ext_prog_ok,
	output logic             ext_verify_ok,
	output logic             fuse_write_ok,
	output logic             boot_lock_write_ok,
	output logic             eeprom_preserve
);

	fblp_pkg::fblp_state_t cur;
	fblp_pkg::fblp_state_t next_cur;

	// =========================================================
	// Lock and fuse fields
	// =========================================================
	logic boot_region_lock_hi;
	logic boot_region_lock_lo;
	logic app_region_lock_hi;
	logic app_region_lock_lo;
	logic memory_lock_hi;
	logic memory_lock_lo;
	logic boot_size_sel_hi;
	logic boot_size_sel_lo;
	logic self_program_enable_fuse;

	assign boot_region_lock_hi = cur.lock[5];
	assign boot_region_lock_lo = cur.lock[4];
	assign app_region_lock_hi  = cur.lock[3];
	assign app_region_lock_lo  = cur.lock[2];
	assign memory_lock_hi      = cur.lock[1];
	assign memory_lock_lo      = cur.lock[0];

	// Decode runs on the latched fuse copy
	assign boot_size_sel_hi = cur.fuse_lat[`FBLP_FUSE_BSZ_HI];
	assign boot_size_sel_lo = cur.fuse_lat[`FBLP_FUSE_BSZ_LO];
	assign self_program_enable_fuse =
		cur.fuse_lat[`FBLP_FUSE_SELFPRG];

	// Preserve fuse acts straight from the image
	assign eeprom_preserve = ~cur.fuse[`FBLP_FUSE_EEPROM_PRESERVE_FUSE];

	// =========================================================
	// Programmer permissions
	// =========================================================
	// Memory lock pair sets the programmer's rights
	always_comb begin
		ext_prog_ok        = 1'b1;
		ext_verify_ok      = 1'b1;
		fuse_write_ok      = 1'b1;
		boot_lock_write_ok = 1'b1;
		case ({memory_lock_hi, memory_lock_lo})
			2'b10: begin
				// Mode 2: no programming, fuses frozen
				ext_prog_ok   = 1'b0;
				fuse_write_ok = 1'b0;
			end
			2'b00: begin
				// Mode 3: verify and boot locks frozen too
				ext_prog_ok        = 1'b0;
				ext_verify_ok      = 1'b0;
				fuse_write_ok      = 1'b0;
				boot_lock_write_ok = 1'b0;
			end
			default: begin
				// Mode 1 and the unused pattern stay open
				ext_prog_ok = 1'b1;
			end
		endcase
	end

	// =========================================================
	// Region and address decode
	// =========================================================
	logic [12:0] pc_word;
	logic        exec_in_boot;
	logic        store_blocked;
	logic        load_blocked;
	logic        app_store_blk;
	logic        app_load_blk;
	logic        app_irq_blk;
	logic        boot_store_blk;
	logic        boot_load_blk;
	logic        boot_irq_blk;

	always_comb begin
		case ({boot_size_sel_hi, boot_size_sel_lo})
			2'b11:   boot_start = `FBLP_BOOT_128;
			2'b10:   boot_start = `FBLP_BOOT_256;
			2'b01:   boot_start = `FBLP_BOOT_512;
			default: boot_start = `FBLP_BOOT_1024;
		endcase
	end

	// Bits 15 and 14 take no part in addressing
	assign flash_word_addr    = acc_zptr[13:1];
	assign page_index         = acc_zptr[13:7];
	assign word_in_page_index = acc_zptr[6:1];
	assign pc_word            = cpu_pc;

	// Boot region runs from its start to the top word
	assign target_in_boot = flash_word_addr >= boot_start;
	assign exec_in_boot   = pc_word >= boot_start;

	// Fixed split, independent of boot size
	assign stalled_read_region =
		flash_word_addr >= `FBLP_STALL_START;
	assign concurrent_read_region = ~stalled_read_region;

	// Application region, cross loads come from the boot side
	always_comb begin
		app_store_blk = 1'b0;
		app_load_blk  = 1'b0;
		app_irq_blk   = 1'b0;
		case ({app_region_lock_hi, app_region_lock_lo})
			2'b10: begin
				app_store_blk = 1'b1;
			end
			2'b00: begin
				app_store_blk = 1'b1;
				app_load_blk  = exec_in_boot;
				app_irq_blk   = ivt_in_boot;
			end
			2'b01: begin
				app_load_blk = exec_in_boot;
				app_irq_blk  = ivt_in_boot;
			end
			default: begin
				app_store_blk = 1'b0;
			end
		endcase
	end

	// Boot region, cross loads come from the application side
	always_comb begin
		boot_store_blk = 1'b0;
		boot_load_blk  = 1'b0;
		boot_irq_blk   = 1'b0;
		case ({boot_region_lock_hi, boot_region_lock_lo})
			2'b10: begin
				boot_store_blk = 1'b1;
			end
			2'b00: begin
				boot_store_blk = 1'b1;
				boot_load_blk  = ~exec_in_boot;
				boot_irq_blk   = ~ivt_in_boot;
			end
			2'b01: begin
				boot_load_blk = ~exec_in_boot;
				boot_irq_blk  = ~ivt_in_boot;
			end
			default: begin
				boot_store_blk = 1'b0;
			end
		endcase
	end

	// Region select, the no-boot variant has one rule
	always_comb begin
		store_blocked = 1'b0;
		load_blocked  = 1'b0;
		if (cur.no_boot) begin
			store_blocked = self_program_enable_fuse;
		end else if (target_in_boot) begin
			store_blocked = boot_store_blk;
			load_blocked  = boot_load_blk;
		end else begin
			store_blocked = app_store_blk;
			load_blocked  = app_load_blk;
		end
	end

	// Decode is purely combinational on latched state
	always_comb begin
		acc_allow = 1'b0;
		if (acc_valid) begin
			if (acc_store) begin
				acc_allow = ~store_blocked;
			end else begin
				acc_allow = ~load_blocked;
			end
		end
	end

	// Refused stores never reach the array
	assign flash_we = acc_valid & acc_store & ~store_blocked;

	always_comb begin
		load_byte = `FBLP_HARMLESS;
		if (acc_valid & ~acc_store & ~load_blocked) begin
			if (acc_zptr[0]) begin
				load_byte = flash_rdata[15:8];
			end else begin
				load_byte = flash_rdata[7:0];
			end
		end
	end

	always_comb begin
		irq_suppress = 1'b0;
		if (!cur.no_boot) begin
			if (!exec_in_boot) begin
				irq_suppress = app_irq_blk;
			end else begin
				irq_suppress = boot_irq_blk;
			end
		end
	end

	// =========================================================
	// APB slave
	// =========================================================
	logic        apb_setup;
	logic        apb_access;
	logic        hit_lock;
	logic        hit_fuse;
	logic        hit_ctrl;
	logic        hit_stat;
	logic        mapped;
	logic        wr_refused;
	logic [7:0]  wbyte;
	logic [31:0] rd_word;

	assign apb_setup  = psel & ~penable;
	assign apb_access = psel & penable;
	assign hit_lock   = paddr == `FBLP_OFS_LOCK;
	assign hit_fuse   = paddr == `FBLP_OFS_FUSE;
	assign hit_ctrl   = paddr == `FBLP_OFS_CTRL;
	assign hit_stat   = paddr == `FBLP_OFS_STAT;
	assign mapped     = hit_lock | hit_fuse | hit_ctrl | hit_stat;
	assign wbyte      = pstrb[0] ? pwdata[7:0] : 8'hFF;

	// Frozen fields answer a write with an error
	always_comb begin
		wr_refused = 1'b0;
		if (pwrite & pstrb[0]) begin
			if (hit_fuse) begin
				wr_refused = ~cur.prog_mode | ~fuse_write_ok;
			end else if (hit_lock) begin
				wr_refused = ~boot_lock_write_ok &
					(wbyte[5:2] != 4'hF);
			end else if (hit_stat) begin
				wr_refused = 1'b1;
			end
		end
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		if (hit_lock) begin
			rd_word[7:0] = cur.lock;
		end else if (hit_fuse) begin
			rd_word[7:0] = cur.fuse;
		end else if (hit_ctrl) begin
			rd_word[`FBLP_CTRL_PROG]   = cur.prog_mode;
			rd_word[`FBLP_CTRL_NOBOOT] = cur.no_boot;
		end else if (hit_stat) begin
			rd_word[7:0]   = cur.fuse_lat;
			rd_word[8]     = ext_prog_ok;
			rd_word[9]     = ext_verify_ok;
			rd_word[10]    = fuse_write_ok;
			rd_word[11]    = boot_lock_write_ok;
			rd_word[28:16] = boot_start;
		end
	end

	assign pready  = 1'b1;
	assign pslverr = apb_access & (~mapped | wr_refused);
	assign prdata  = cur.prdata;

	// =========================================================
	// State update
	// =========================================================
	logic       do_write;
	logic [7:0] lock_used;
	logic [7:0] lock_after_write;

	assign lock_used = `FBLP_LOCK_USED;

	// Used bits only move toward programmed
	for (genvar gi = 0; gi < 8; gi++) begin : g_lock_bit
		assign lock_after_write[gi] = cur.lock[gi] &
			(wbyte[gi] | ~lock_used[gi]);
	end

	assign do_write = apb_access & pwrite & pstrb[0] & mapped &
		~wr_refused;

	always_comb begin
		next_cur = cur;
		next_cur.cap_pend = 1'b0;
		if (apb_setup) begin
			next_cur.prdata = rd_word;
		end
		// Power-up capture, one cycle after reset release
		if (cur.cap_pend) begin
			next_cur.fuse_lat = cur.fuse;
		end
		if (do_write && hit_lock) begin
			// Writes can only program bits toward 0
			next_cur.lock = lock_after_write;
		end
		if (do_write && hit_fuse) begin
			next_cur.fuse = (cur.fuse & ~`FBLP_FUSE_USED) |
				(wbyte & `FBLP_FUSE_USED);
		end
		if (do_write && hit_ctrl) begin
			next_cur.prog_mode = wbyte[`FBLP_CTRL_PROG];
			next_cur.no_boot   = wbyte[`FBLP_CTRL_NOBOOT];
			// Entry and exit both relatch the fuses
			if (wbyte[`FBLP_CTRL_PROG] != cur.prog_mode) begin
				next_cur.fuse_lat = cur.fuse;
			end
			// Chip erase clears locks, never fuses
			if (wbyte[`FBLP_CTRL_ERASE] && cur.prog_mode) begin
				next_cur.lock = `FBLP_LOCK_RESET;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cur.lock      <= `FBLP_LOCK_RESET;
			cur.fuse      <= `FBLP_FUSE_RESET;
			cur.fuse_lat  <= `FBLP_FUSE_RESET;
			cur.prog_mode <= 1'b0;
			cur.no_boot   <= 1'b0;
			cur.cap_pend  <= 1'b1;
			cur.prdata    <= 32'h0000_0000;
		end else begin
			cur <= next_cur;
		end
	end

endmodule

`default_nettype wire

// *** tb/fblp_flash_model.sv ***
// Program flash array model on the far side of the lock block.
// Assumes a word address from fblp_top, answered in the same cycle.
`timescale 1ns/1ps
`default_nettype none

module fblp_flash_model (
	// Flash read port
	input  wire logic [12:0] flash_word_addr,
	output logic      [15:0] flash_rdata
);
	// Address-derived pattern, differs in both bytes
	assign flash_rdata = {3'b000, flash_word_addr} ^ 16'h5AC3;
endmodule

`default_nettype wire

// *** tb/fblp_top_assertions.sv ***
// Port relations of the flash lock block.
// Assumes it is bound into fblp_top.
`timescale 1ns/1ps
`default_nettype none

module fblp_assertions (
	// Clock, reset, bus
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	// Core side
	input wire logic        acc_valid,
	input wire logic        acc_store,
	input wire logic [15:0] acc_zptr,
	input wire logic [15:0] flash_rdata,
	input wire logic        acc_allow,
	input wire logic        flash_we,
	input wire logic [12:0] flash_word_addr,
	input wire logic [6:0]  page_index,
	input wire logic [5:0]  word_in_page_index,
	input wire logic [7:0]  load_byte,
	input wire logic [12:0] boot_start,
	input wire logic        target_in_boot,
	input wire logic        concurrent_read_region,
	input wire logic        stalled_read_region,
	input wire logic        ext_prog_ok,
	input wire logic        ext_verify_ok
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ====
	// Properties
	a_zptr_split: assert property (
		page_index == acc_zptr[13:7] && flash_word_addr == acc_zptr[13:1]
		&& word_in_page_index == acc_zptr[6:1]) else $error("Pointer split");
	a_rww_limit: assert property (
		concurrent_read_region == (flash_word_addr < 13'h1C00)
		&& stalled_read_region != concurrent_read_region) else $error("CONCURRENT_READ_REGION");
	a_boot_side: assert property (
		target_in_boot == (flash_word_addr >= boot_start)) else $error("Side");
	a_store_gate: assert property (
		flash_we |-> acc_valid && acc_store && acc_allow) else $error("WE");
	a_load_harm: assert property (
		acc_valid && !acc_store && !acc_allow |-> load_byte == 8'hFF)
		else $error("Refused load value");
	a_load_sel: assert property (
		acc_valid && !acc_store && acc_allow |-> load_byte ==
		(acc_zptr[0] ? flash_rdata[15:8] : flash_rdata[7:0]))
		else $error("Load byte");
	a_lock_rise: assert property (
		$rose(ext_prog_ok) |-> $past(psel && penable && pwrite
		&& paddr == 12'h008 && pwdata[1])) else $error("Lock cleared");
	a_mode_order: assert property (
		!ext_verify_ok |-> !ext_prog_ok) else $error("Lock modes");
endmodule

bind fblp_top fblp_assertions u_fblp_assertions (.*);

`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench of the flash lock block.
// Assumes fblp_top, the flash model and the checker compile first.
`timescale 1ns/1ps
`include "fblp_map.svh"
`default_nettype none

module tb_top;
	logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
	logic        acc_valid, acc_store, ivt_in_boot, acc_allow, flash_we;
	logic        irq_suppress, target_in_boot, eeprom_preserve;
	logic        concurrent_read_region, stalled_read_region, er, nb;
	logic        ext_prog_ok, ext_verify_ok, fuse_write_ok;
	logic        boot_lock_write_ok;
	logic [1:0]  e;
	logic [3:0]  pstrb;
	logic [5:0]  word_in_page_index;
	logic [6:0]  page_index;
	logic [7:0]  load_byte, lk, f, lb;
	logic [11:0] paddr;
	logic [12:0] cpu_pc, boot_start, flash_word_addr, bs;
	logic [15:0] acc_zptr, flash_rdata;
	logic [31:0] pwdata, prdata, rd, s;
	int          errors, checks;

	fblp_top u_fblp_top (.*);
	fblp_flash_model u_fblp_flash_model (.*);

	// ====
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	function automatic logic [12:0] bsf(input logic [1:0] c);
		case (c)
			2'b11: return 13'h1F80;
			2'b10: return 13'h1F00;
			2'b01: return 13'h1E00;
			default: return 13'h1C00;
		endcase
	endfunction

	// Permission and interrupt mask from lock byte and addresses
	function automatic logic [1:0] exp_acc(input logic [12:0] a);
		logic t, p, ok;
		t = a >= bs;
		p = cpu_pc >= bs;
		if (acc_store)
			ok = nb ? !f[4] : (t ? lk[4] : lk[2]);
		else
			ok = nb || !(t ? !lk[5] && !p : !lk[3] && p);
		return {ok, !nb && (!p && !lk[3] && ivt_in_boot
			|| p && !lk[5] && !ivt_in_boot)};
	endfunction

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic chk_word(input logic [31:0] g, input logic [31:0] x);
		checks++;
		if (g !== x) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, x);
		end
	endtask

	task automatic chk_bit(input logic g, input logic x);
		chk_word({31'h0, g}, {31'h0, x});
	endtask

	task automatic finish_test;
		$display("Checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ====
	// Clock, watchdog, tests
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		finish_test();
	end

	initial begin
		{rst, psel, penable, pwrite, acc_valid, acc_store} <= 6'h20;
		{ivt_in_boot, paddr, pwdata, cpu_pc, acc_zptr} <= '0;
		pstrb <= 4'hF;
		s = 32'd65;
		errors = 0;
		checks = 0;
		bs = 13'h1C00;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		apb(1'b0, `FBLP_OFS_LOCK, 0);
		chk_word(rd, 32'h0000_00FF);
		apb(1'b0, `FBLP_OFS_STAT, 0);
		chk_word(rd, 32'h1C00_0FF9);
		apb(1'b0, 12'h010, 0);
		chk_bit(er, 1'b1);
		$display("Test reset done");
		for (int l = 0; l < 64; l++) begin
			s = xs(s);
			f = {3'b111, s[3:0], 1'b1};
			nb = s[4];
			lk = {2'b11, 6'(l)};
			apb(1'b1, `FBLP_OFS_CTRL, 32'h1);
			apb(1'b1, `FBLP_OFS_CTRL, 32'h3);
			apb(1'b1, `FBLP_OFS_FUSE, {24'h0, f});
			chk_bit(eeprom_preserve, ~f[3]);
			chk_word({19'h0, boot_start}, {19'h0, bs});
			bs = bsf(f[2:1]);
			apb(1'b1, `FBLP_OFS_CTRL, {29'h0, nb, 2'b00});
			apb(1'b1, `FBLP_OFS_LOCK, {24'h0, lk});
			apb(1'b1, `FBLP_OFS_LOCK, 32'hFF);
			apb(1'b0, `FBLP_OFS_LOCK, 0);
			chk_word(rd, {24'h0, lk});
			apb(1'b0, `FBLP_OFS_STAT, 0);
			chk_word(rd, {3'b000, bs, 4'h0, lk[1] | lk[0], lk[0],
				lk[1] | lk[0], lk[0], f});
			apb(1'b1, `FBLP_OFS_CTRL, 32'h1);
			apb(1'b1, `FBLP_OFS_FUSE, {24'h0, f});
			chk_bit(er, ~lk[0]);
			apb(1'b1, `FBLP_OFS_CTRL, {29'h0, nb, 2'b00});
			repeat (8) begin
				s = xs(s);
				acc_valid <= s[0];
				acc_store <= s[1];
				ivt_in_boot <= s[2];
				cpu_pc <= s[15:3];
				acc_zptr <= {s[31:17], !s[1] & s[16]};
				#1;
				e = exp_acc(acc_zptr[13:1]);
				chk_bit(acc_allow, acc_valid & e[1]);
				chk_bit(flash_we, acc_valid & acc_store & e[1]);
				chk_bit(irq_suppress, e[0]);
				lb = acc_zptr[0] ? flash_rdata[15:8] : flash_rdata[7:0];
				if (!acc_valid || acc_store || !e[1])
					lb = 8'hFF;
				chk_word({24'h0, load_byte}, {24'h0, lb});
				chk_bit(stalled_read_region, &acc_zptr[13:11]);
				@(posedge clk_sys);
			end
			apb(1'b1, `FBLP_OFS_LOCK, 32'hC0);
			chk_bit(er, lk[1:0] == 2'b00);
		end
		$display("Test lock modes done");
		finish_test();
	end
endmodule

`default_nettype wire
